// *** emw_pkg.sv ***
// Constants and types for the external memory write/select pin block
package emw_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int PUR_PIN8_BIT = 8;
  localparam int PUR_PIN9_BIT = 9;
  localparam int SETUP_CYC = 1;
  localparam int STROBE_CYC = 2;
  localparam int HOLD_CYC = 1;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic IDLE_DRIVE_RST = 1'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    EMW_IDLE = 2'b00,
    EMW_SETUP = 2'b01,
    EMW_STROBE = 2'b10,
    EMW_HOLD = 2'b11
  } emw_state_e;
endpackage

// *** emw_sel_pin.sv ***
// One select pin with chip-select or general-purpose port D use
module emw_sel_pin (
  input wire logic gpio_mode_in, // Pin used as port D GPIO
  input wire logic gpio_dir_out_in, // GPIO direction, 1 = output
  input wire logic gpio_val_in, // GPIO output value
  input wire logic pullup_bit_in, // Port D pull-up bit, 1 = enabled
  input wire logic sel_active_in, // Select asserted this cycle
  input wire logic bus_on_in, // Bus pins driven this cycle
  output logic pin_o_out, // Pin output level
  output logic pin_oe_out, // Pin output enable
  output logic pin_pu_out // Pin pull-up enable
);
  always_comb begin
    if (gpio_mode_in) begin
      pin_o_out = gpio_val_in;
      pin_oe_out = gpio_dir_out_in;
      pin_pu_out = pullup_bit_in;
    end else begin
      pin_o_out = ~sel_active_in;
      pin_oe_out = bus_on_in;
      pin_pu_out = 1'b1;
    end
  end
endmodule // emw_sel_pin

// *** emw_ext_mem.sv ***
// External memory interface strobes, selects, address and data pins
module emw_ext_mem (
  input wire logic clk_in, // 10 MHz clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic req_in, // Access request pulse
  input wire logic req_write_in, // 1 = write, 0 = read
  input wire logic req_prog_in, // 1 = program space, 0 = data space
  input wire logic [23:0] req_addr_in, // Access address
  input wire logic [15:0] req_wdata_in, // Write data
  output logic busy_out, // Access in progress
  output logic done_out, // Access finished pulse
  output logic [15:0] rdata_out, // Latched read data
  input wire logic idle_drive_bit_in, // Bus control idle drive bit
  input wire logic pullup_disable_ctrl_in, // Pad control bit, 1 = strobe pull-ups off
  input wire logic [15:0] port_d_pullup_reg_in, // Port D pull-up register
  input wire logic pin_eight_gpio_in, // Program select pin as port D pin eight
  input wire logic pin_nine_gpio_in, // Data select pin as port D pin nine
  input wire logic [1:0] gpio_dir_in, // Pins nine/eight direction, 1 = output
  input wire logic [1:0] gpio_val_in, // Pins nine/eight output value
  output logic [1:0] gpio_pin_in_out, // Pins nine/eight synchronised input
  output logic wr_n_o_out, // Write strobe level
  output logic wr_n_oe_out, // Write strobe enable
  output logic wr_n_pu_out, // Write strobe pull-up
  output logic rd_n_o_out, // Read strobe level
  output logic rd_n_oe_out, // Read strobe enable
  output logic rd_n_pu_out, // Read strobe pull-up
  output logic program_mem_select_n_o_out, // Program select level
  output logic program_mem_select_n_oe_out, // Program select enable
  output logic program_mem_select_n_pu_out, // Program select pull-up
  input wire logic program_mem_select_n_i_in, // Program select pin input
  output logic data_mem_select_n_o_out, // Data select level
  output logic data_mem_select_n_oe_out, // Data select enable
  output logic data_mem_select_n_pu_out, // Data select pull-up
  input wire logic data_mem_select_n_i_in, // Data select pin input
  output logic [23:0] addr_o_out, // Address bus
  output logic addr_oe_out, // Address bus enable
  output logic [15:0] data_o_out, // Data bus out
  output logic data_oe_out, // Data bus enable
  input wire logic [15:0] data_i_in // Data bus pin input
);
  emw_pkg::emw_state_e state_ff;
  emw_pkg::emw_state_e nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic wr_ff;
  logic nxt_wr;
  logic prog_ff;
  logic nxt_prog;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [15:0] wdata_ff;
  logic [15:0] nxt_wdata;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic done_ff;
  logic nxt_done;
  logic in_rst_ff;
  logic nxt_in_rst;
  logic [15:0] din_s1_ff;
  logic [15:0] nxt_din_s1;
  logic [15:0] din_s2_ff;
  logic [15:0] nxt_din_s2;
  logic [1:0] gp_s1_ff;
  logic [1:0] nxt_gp_s1;
  logic [1:0] gp_s2_ff;
  logic [1:0] nxt_gp_s2;
  logic active;
  logic strobe;
  logic bus_on;
  logic prog_sel;
  logic data_sel;

  // Last cycle of a phase; shared by setup, strobe and hold
  function automatic logic cnt_last(input logic [1:0] cnt);
    return cnt == emw_pkg::CNT_ONE;
  endfunction

  // Pin inputs pass two flops before use; only the second stage feeds logic
  always_comb begin
    nxt_din_s1 = data_i_in;
    nxt_din_s2 = din_s1_ff;
    nxt_gp_s1 = {data_mem_select_n_i_in, program_mem_select_n_i_in};
    nxt_gp_s2 = gp_s1_ff;
    nxt_in_rst = 1'b0;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      din_s1_ff <= emw_pkg::DATA_RST;
      din_s2_ff <= emw_pkg::DATA_RST;
      gp_s1_ff <= 2'h0;
      gp_s2_ff <= 2'h0;
      in_rst_ff <= 1'b1;
    end else begin
      din_s1_ff <= nxt_din_s1;
      din_s2_ff <= nxt_din_s2;
      gp_s1_ff <= nxt_gp_s1;
      gp_s2_ff <= nxt_gp_s2;
      in_rst_ff <= nxt_in_rst;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_prog = prog_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_done = 1'b0;
    unique case (state_ff)
      emw_pkg::EMW_IDLE: begin
        if (req_in) begin
          nxt_wr = req_write_in;
          nxt_prog = req_prog_in;
          nxt_addr = req_addr_in;
          nxt_wdata = req_wdata_in;
          nxt_cnt = 2'(emw_pkg::SETUP_CYC);
          nxt_state = emw_pkg::EMW_SETUP;
        end
      end
      emw_pkg::EMW_SETUP: begin
        if (cnt_last(cnt_ff)) begin
          nxt_cnt = 2'(emw_pkg::STROBE_CYC);
          nxt_state = emw_pkg::EMW_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      emw_pkg::EMW_STROBE: begin
        if (cnt_last(cnt_ff)) begin
          nxt_cnt = 2'(emw_pkg::HOLD_CYC);
          nxt_state = emw_pkg::EMW_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
      emw_pkg::EMW_HOLD: begin
        if (cnt_last(cnt_ff)) begin
          // Two-flop delay: the second stage now shows the pins as seen under
          // the strobe; relies on a one-cycle hold, a longer one would need a tap
          if (!wr_ff) begin
            nxt_rdata = din_s2_ff;
          end
          nxt_done = 1'b1;
          nxt_state = emw_pkg::EMW_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= emw_pkg::EMW_IDLE;
      cnt_ff <= 2'h0;
      wr_ff <= 1'b0;
      prog_ff <= 1'b0;
      addr_ff <= 24'h000000;
      wdata_ff <= emw_pkg::DATA_RST;
      rdata_ff <= emw_pkg::DATA_RST;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      prog_ff <= nxt_prog;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      done_ff <= nxt_done;
    end
  end

  assign active = (state_ff != emw_pkg::EMW_IDLE);
  assign strobe = (state_ff == emw_pkg::EMW_STROBE);
  // Idle drive bit chooses driven (strobes and selects high) or released pins when idle; reset releases all but GPIO-mode select pins
  assign bus_on = !in_rst_ff && (active || idle_drive_bit_in);

  assign busy_out = active;
  assign done_out = done_ff;
  assign rdata_out = rdata_ff;
  assign gpio_pin_in_out = gp_s2_ff;

  assign wr_n_o_out = ~(strobe && wr_ff);
  assign wr_n_oe_out = bus_on;
  assign wr_n_pu_out = ~pullup_disable_ctrl_in;
  assign rd_n_o_out = ~(strobe && !wr_ff);
  assign rd_n_oe_out = bus_on;
  assign rd_n_pu_out = ~pullup_disable_ctrl_in;
  // Address and selects stay valid across setup, strobe and hold
  assign addr_o_out = addr_ff;
  assign addr_oe_out = bus_on;
  assign data_o_out = wdata_ff;
  // Data driven through hold so it is valid at the strobe's rising edge
  assign data_oe_out = active && wr_ff && (state_ff != emw_pkg::EMW_SETUP);
  // Each select follows its space for the whole access, setup to hold
  assign prog_sel = active && prog_ff;
  assign data_sel = active && !prog_ff;

  emw_sel_pin u_prog_sel (
    .gpio_mode_in(pin_eight_gpio_in),
    .gpio_dir_out_in(gpio_dir_in[0]),
    .gpio_val_in(gpio_val_in[0]),
    .pullup_bit_in(port_d_pullup_reg_in[emw_pkg::PUR_PIN8_BIT]),
    .sel_active_in(prog_sel),
    .bus_on_in(bus_on),
    .pin_o_out(program_mem_select_n_o_out),
    .pin_oe_out(program_mem_select_n_oe_out),
    .pin_pu_out(program_mem_select_n_pu_out)
  );

  emw_sel_pin u_data_sel (
    .gpio_mode_in(pin_nine_gpio_in),
    .gpio_dir_out_in(gpio_dir_in[1]),
    .gpio_val_in(gpio_val_in[1]),
    .pullup_bit_in(port_d_pullup_reg_in[emw_pkg::PUR_PIN9_BIT]),
    .sel_active_in(data_sel),
    .bus_on_in(bus_on),
    .pin_o_out(data_mem_select_n_o_out),
    .pin_oe_out(data_mem_select_n_oe_out),
    .pin_pu_out(data_mem_select_n_pu_out)
  );
endmodule // emw_ext_mem

// *** emw_sva.sv ***
// Assertion checker for the external memory pin block
module emw_chk (
  input wire logic clk_in, // Clock
  input wire logic nrst_in, // Reset
  input wire logic req_in, // Request
  input wire logic req_write_in, // Write
  input wire logic req_prog_in, // Program space
  input wire logic busy_out, // Busy
  input wire logic idle_drive_bit_in, // Idle drive
  input wire logic pullup_disable_ctrl_in, // Pull-up off
  input wire logic pin_eight_gpio_in, // Pin eight GPIO
  input wire logic pin_nine_gpio_in, // Pin nine GPIO
  input wire logic wr_n_o_out, // Strobe
  input wire logic wr_n_oe_out, // Strobe enable
  input wire logic wr_n_pu_out, // Strobe pull-up
  input wire logic rd_n_o_out, // Read strobe
  input wire logic data_oe_out, // Data enable
  input wire logic program_mem_select_n_o_out, // Program select
  input wire logic program_mem_select_n_oe_out, // Its enable
  input wire logic data_mem_select_n_o_out, // Data select
  input wire logic addr_oe_out // Address enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence taken; req_in && !busy_out; endsequence
  // Two edges of grace after reset, and none while the drive bit moves
  sequence idle; !busy_out && $past(nrst_in, 2) && $stable(idle_drive_bit_in); endsequence
  a_wr_strobe_time: assert property (taken ##0 req_write_in |-> ##2 !wr_n_o_out [*2] ##1 wr_n_o_out)
    else $error("write strobe timing wrong");
  a_data_driven: assert property (!wr_n_o_out |-> data_oe_out)
    else $error("data not driven under strobe");
  a_data_hold: assert property ($rose(wr_n_o_out) && busy_out |-> data_oe_out)
    else $error("data dropped at strobe end");
  a_addr_qual: assert property (!wr_n_o_out |-> addr_oe_out && busy_out)
    else $error("strobe without address");
  a_rd_strobe_time: assert property (taken ##0 !req_write_in |-> ##2 !rd_n_o_out [*2] ##1 rd_n_o_out)
    else $error("read strobe timing wrong");
  a_rd_bus_in: assert property (!rd_n_o_out |-> !data_oe_out)
    else $error("data driven under read strobe");
  a_wr_idle: assert property (idle |-> wr_n_oe_out == idle_drive_bit_in && wr_n_o_out)
    else $error("idle strobe drive wrong");
  a_wr_reset: assert property (disable iff (1'b0) !nrst_in |-> !wr_n_oe_out && wr_n_pu_out != pullup_disable_ctrl_in)
    else $error("strobe reset state wrong");
  a_sel_idle: assert property (idle ##0 !pin_eight_gpio_in |->
    program_mem_select_n_oe_out == idle_drive_bit_in && addr_oe_out == idle_drive_bit_in)
    else $error("idle select drive wrong");
  a_prog_select: assert property (taken ##0 req_prog_in && !pin_eight_gpio_in |=>
    !program_mem_select_n_o_out [*4] ##1 program_mem_select_n_o_out)
    else $error("program select wrong");
  a_data_select: assert property (taken ##0 !req_prog_in && !pin_nine_gpio_in |=>
    !data_mem_select_n_o_out [*4] ##1 data_mem_select_n_o_out)
    else $error("data select wrong");
endmodule // emw_chk
bind emw_ext_mem emw_chk u_chk (.*);

// *** emw_sram.sv ***
// Behavioural static RAM on the far side of the memory pins
module emw_sram (
  input wire logic wr_in, // Write strobe asserted
  input wire logic rd_in, // Read strobe asserted
  input wire logic psel_in, // Program select asserted
  input wire logic dsel_in, // Data select asserted
  input wire logic [3:0] addr_in, // Low address bits
  input wire logic [15:0] bus_in, // Data pins
  output logic [15:0] bus_out, // Read data
  output logic drive_out // Drives data pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [32];
  // Captured on the trailing edge, so late data is caught
  always @(negedge wr_in) begin
    if (psel_in ^ dsel_in) begin
      mem[{psel_in, addr_in}] = bus_in;
    end
  end
  assign drive_out = rd_in && (psel_in ^ dsel_in);
  assign bus_out = mem[{psel_in, addr_in}];
endmodule // emw_sram

// *** tb.sv ***
// Self-checking bench for the external memory pin block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, nrst_in = 1, req_in = 0, req_write_in = 0, req_prog_in = 0, idle_drive_bit_in = 1;
  logic pullup_disable_ctrl_in = 0, pin_eight_gpio_in = 0, pin_nine_gpio_in = 0, data_oe_out, moe;
  logic [23:0] req_addr_in = 24'h0, addr_o_out;
  logic [15:0] req_wdata_in = 16'h0, port_d_pullup_reg_in = 16'h0300, data_i_in, data_o_out, rdata_out, mbus;
  logic [15:0] last = 16'h0;
  logic [1:0] gpio_dir_in = 2'h0, gpio_val_in = 2'h0, gpio_pin_in_out;
  logic busy_out, done_out, wr_n_o_out, wr_n_oe_out, wr_n_pu_out, rd_n_o_out, rd_n_oe_out, rd_n_pu_out, addr_oe_out;
  logic program_mem_select_n_o_out, program_mem_select_n_oe_out, program_mem_select_n_pu_out, program_mem_select_n_i_in;
  logic data_mem_select_n_o_out, data_mem_select_n_oe_out, data_mem_select_n_pu_out, data_mem_select_n_i_in;
  logic [15:0] ref_m [32];
  int seed = 72, n_fail = 0, tests_run = 0;
  always #50 clk_in = ~clk_in;
  emw_ext_mem DUT (.*);
  emw_sram u_mem (.wr_in(wr_n_oe_out & ~wr_n_o_out), .rd_in(rd_n_oe_out & ~rd_n_o_out),
    .psel_in(program_mem_select_n_oe_out & ~program_mem_select_n_o_out),
    .dsel_in(data_mem_select_n_oe_out & ~data_mem_select_n_o_out), .addr_in(addr_o_out[3:0]),
    .bus_in(data_i_in), .bus_out(mbus), .drive_out(moe));
  // Released bus toggles so a stale value never reads back by luck
  assign data_i_in = data_oe_out ? data_o_out : (moe ? mbus : ~last);
  assign program_mem_select_n_i_in = program_mem_select_n_oe_out ? program_mem_select_n_o_out : program_mem_select_n_pu_out;
  assign data_mem_select_n_i_in = data_mem_select_n_oe_out ? data_mem_select_n_o_out : data_mem_select_n_pu_out;
  always @(posedge clk_in) last <= data_i_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] exp_rd(input logic p, input logic [3:0] a);
    return ref_m[{p, a}];
  endfunction
  function automatic logic [5:0] gp_exp(input logic [1:0] d, input logic [1:0] v, input logic [15:0] u);
    return {d, u[9], u[8], d[1] ? v[1] : u[9], d[0] ? v[0] : u[8]};
  endfunction
  task automatic acc(input logic w, input logic p, input logic [3:0] a, input logic [15:0] d, input logic drv);
    req_in <= 1'h1;
    req_write_in <= w;
    req_prog_in <= p;
    req_addr_in <= {20'($random(seed)), a};
    req_wdata_in <= d;
    idle_drive_bit_in <= drv;
    @(posedge clk_in);
    // A stray second request while busy must be ignored
    req_in <= 1'($random(seed));
    @(posedge clk_in);
    req_in <= 1'h0;
    // Done stands in the fifth cycle after the taking edge
    repeat (3) @(posedge clk_in);
    #1 chk(16'(done_out), 16'h1);
    chk_addr(addr_o_out, req_addr_in);
    if (w) begin
      ref_m[{p, a}] = d;
      chk(data_o_out, d);
    end else begin
      chk(rdata_out, exp_rd(p, a));
    end
    @(posedge clk_in);
    #1 chk(16'(busy_out), 16'h0);
    @(posedge clk_in);
  endtask
  initial begin
    // Reset falls in the update phase so the asynchronous reset branches see an edge
    nrst_in <= 1'h0;
    pullup_disable_ctrl_in = 1'($random(seed));
    repeat (20) @(posedge clk_in);
    #1 chk(16'({wr_n_oe_out, wr_n_pu_out, rd_n_oe_out, rd_n_pu_out, program_mem_select_n_oe_out,
      data_mem_select_n_oe_out, addr_oe_out, data_oe_out}),
      16'({1'h0, ~pullup_disable_ctrl_in, 1'h0, ~pullup_disable_ctrl_in, 4'h0}));
    @(posedge clk_in);
    nrst_in <= 1'h1;
    for (int i = 0; i < 32; i++) acc(1'h1, i[4], i[3:0], 16'($random(seed)), 1'h1);
    for (int i = 0; i < 60; i++) begin
      acc(1'($random(seed)), 1'($random(seed)), 4'($random(seed)), 16'($random(seed)), 1'($random(seed)));
    end
    pin_eight_gpio_in <= 1'h1;
    pin_nine_gpio_in <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      gpio_dir_in <= 2'(i);
      gpio_val_in <= 2'($random(seed));
      port_d_pullup_reg_in <= 16'($random(seed));
      repeat (3) @(posedge clk_in);
      #1 chk(16'({data_mem_select_n_oe_out, program_mem_select_n_oe_out, data_mem_select_n_pu_out,
        program_mem_select_n_pu_out, gpio_pin_in_out}), 16'(gp_exp(gpio_dir_in, gpio_val_in, port_d_pullup_reg_in)));
      @(posedge clk_in);
    end
    give_verdict();
  end
endmodule // tb
